// ===== logic/acc_ctrl.sv
/*
  Configuration word, limits and pointer behind a byte-level target port,
  plus conversion sequencing and the alert pin.
  Assumes an external bus engine that delivers framed bytes on mclk and
  an analog core that reports results with conv_done.
*/
// Functional notes
// - Hold 16-bit config word with trigger, input, gain, mode, rate, comparator fields.
// - Writing trigger 1 starts one conversion only when powered down.
// - Trigger bit reads 0 during conversion, 1 when idle.
// - Input select picks four differential pairs or four single-ended inputs.
// - Gain field selects full-scale range; codes 101 to 111 identical.
// - Mode bit 0 continuous, 1 single-shot with power-down, default.
// - Rate field selects 128 to 3300 samples per second.
// - Style bit picks traditional or window comparator.
// - Polarity bit picks active low or active high alert.
// - Non-latching alert clears once results return inside the limits in window mode, or fall to the lower limit in traditional mode.
// - Latched alert holds until data read or alert response.
// - Alert response answers own address; lowest asserting address wins.
// - Queue code 11 disables comparator and floats alert pin.
// - Alert asserts after one, two or four successive exceedances.
// - Pointer 01 selects config; reads return last pointed register.
// - Registers travel as two bytes, most significant first.
// - Upper MSB 1 and lower MSB 0 turn alert into ready signal.
// - Ready mode mirrors status in single-shot, pulses in continuous.
`timescale 1ns/1ps
`include "acc_defs.svh"

module acc_ctrl #(
  parameter logic [6:0] OWN_ADDR = 7'h48 // Arbitrary target address
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Framed bytes from the bus engine
  input wire logic frame_start,
  input wire logic wr_byte_valid,
  input wire logic [7:0] wr_byte,
  input wire logic rd_byte_req,
  output logic [7:0] rd_byte,
  input wire logic alert_resp,
  output logic [7:0] alert_resp_byte,
  // Converter core
  output logic conv_start,
  output logic conv_continuous,
  output logic [2:0] input_pair_select,
  output logic [2:0] gain_range_select,
  output logic [2:0] rate_select,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  // Alert pin
  output logic alert_out,
  output logic alert_oe,
  // Status
  output logic busy
);

  logic [15:0] cfg;
  logic [15:0] next_cfg;
  logic [15:0] upper_limit;
  logic [15:0] next_upper;
  logic [15:0] lower_limit;
  logic [15:0] next_lower;
  logic [15:0] result;
  logic [15:0] next_result;
  logic [1:0] ptr;
  logic [1:0] next_ptr;
  logic [7:0] hi_hold;
  logic [7:0] next_hi_hold;
  logic rd_second;
  logic next_rd_second;
  logic next_busy;
  logic next_start;
  logic [7:0] next_rd_byte;
  logic [7:0] next_resp_byte;
  logic latch_clear;
  logic alert_active;
  acc_pkg::acc_wstate_t wstate;
  acc_pkg::acc_wstate_t next_wstate;

  // Read view of a register; trigger bit shows idle status
  function automatic logic [15:0] reg_view(input logic [1:0] p, input logic [15:0] c,
                                           input logic [15:0] r, input logic [15:0] lo,
                                           input logic [15:0] hi, input logic bz);
    unique case (p)
      `ACC_PTR_RESULT: reg_view = r;
      `ACC_PTR_CONFIG: reg_view = {!bz, c[14:0]};
      `ACC_PTR_LOWER: reg_view = lo;
      default: reg_view = hi;
    endcase
  endfunction : reg_view

  // Byte writes: pointer, then high byte, then low byte
  always_comb begin
    next_wstate = wstate;
    next_ptr = ptr;
    next_hi_hold = hi_hold;
    next_cfg = cfg;
    next_upper = upper_limit;
    next_lower = lower_limit;
    next_start = 1'b0;
    next_busy = busy;
    if (frame_start)
      next_wstate = acc_pkg::ACC_IDLE;
    else if (wr_byte_valid) begin
      unique case (wstate)
        acc_pkg::ACC_IDLE: begin
          next_ptr = wr_byte[1:0];
          next_wstate = acc_pkg::ACC_RX_HI;
        end
        acc_pkg::ACC_RX_HI: begin
          next_hi_hold = wr_byte;
          next_wstate = acc_pkg::ACC_RX_LO;
        end
        acc_pkg::ACC_RX_LO: begin
          next_wstate = acc_pkg::ACC_IDLE;
          unique case (ptr)
            `ACC_PTR_CONFIG: begin
              next_cfg = {cfg[15], hi_hold[6:0], wr_byte};
              // Only a powered-down single-shot device accepts a trigger
              if (hi_hold[7] && !busy && hi_hold[0]) begin
                next_start = 1'b1;
                next_busy = 1'b1;
              end
            end
            `ACC_PTR_LOWER: next_lower = {hi_hold, wr_byte[7:4], 4'h0};
            `ACC_PTR_UPPER: next_upper = {hi_hold, wr_byte[7:4], 4'hf};
            default: ;
          endcase
        end
        default: next_wstate = acc_pkg::ACC_IDLE;
      endcase
    end
    // Continuous mode runs free; single-shot ends busy on completion
    if (!next_cfg[`ACC_BIT_MODE])
      next_busy = 1'b1;
    else if (conv_done && !next_start)
      next_busy = 1'b0;
    else if (cfg[`ACC_BIT_MODE] == 1'b0)
      next_busy = 1'b0;
  end

  // Read bytes: high then low, restart each frame
  always_comb begin
    logic [15:0] view;
    view = reg_view(ptr, cfg, result, lower_limit, upper_limit, busy);
    next_rd_second = rd_second;
    next_rd_byte = rd_byte;
    next_result = conv_done ? {conv_data[15:4], 4'h0} : result;
    latch_clear = 1'b0;
    if (frame_start)
      next_rd_second = 1'b0;
    else if (rd_byte_req) begin
      next_rd_byte = rd_second ? view[7:0] : view[15:8];
      next_rd_second = !rd_second;
      latch_clear = (ptr == `ACC_PTR_RESULT);
    end
    // Only a device whose own alert is active answers the response
    next_resp_byte = alert_resp_byte;
    if (alert_resp && alert_active) begin
      next_resp_byte = {OWN_ADDR, 1'b0};
      latch_clear = 1'b1;
    end
  end

  // Register all state; reset gives documented defaults
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wstate <= acc_pkg::ACC_IDLE;
      ptr <= `ACC_PTR_RESULT;
      hi_hold <= 8'h00;
      cfg <= `ACC_CFG_RESET;
      upper_limit <= `ACC_UPPER_RESET;
      lower_limit <= `ACC_LOWER_RESET;
      result <= 16'h0000;
      busy <= 1'b0;
      conv_start <= 1'b0;
      rd_second <= 1'b0;
      rd_byte <= 8'h00;
      alert_resp_byte <= 8'hff;
    end else begin
      wstate <= next_wstate;
      ptr <= next_ptr;
      hi_hold <= next_hi_hold;
      cfg <= next_cfg;
      upper_limit <= next_upper;
      lower_limit <= next_lower;
      result <= next_result;
      busy <= next_busy;
      conv_start <= next_start;
      rd_second <= next_rd_second;
      rd_byte <= next_rd_byte;
      alert_resp_byte <= next_resp_byte;
    end
  end

  // Field outputs to the converter core
  assign conv_continuous = !cfg[`ACC_BIT_MODE];
  assign input_pair_select = cfg[14:12];
  assign gain_range_select = cfg[11:9];
  assign rate_select = cfg[7:5];

  // Comparator and pin driver
  acc_alert u_alert (
    .mclk(mclk),
    .nrst(nrst),
    .cfg(cfg),
    .upper_limit(upper_limit),
    .lower_limit(lower_limit),
    .busy(busy),
    .conv_done(conv_done),
    .conv_data(conv_data),
    .latch_clear(latch_clear),
    .alert_out(alert_out),
    .alert_oe(alert_oe),
    .alert_active(alert_active)
  );

endmodule : acc_ctrl

// ===== logic/acc_defs.svh
/*
  Constants for the converter configuration and alert control block:
  register pointers, field positions, reset values and timing counts.
  Assumes inclusion by bare name from the design modules and the bench.
*/
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

`define ACC_PTR_RESULT 2'h0
`define ACC_PTR_CONFIG 2'h1
`define ACC_PTR_LOWER 2'h2
`define ACC_PTR_UPPER 2'h3

`define ACC_CFG_RESET 16'h8583
`define ACC_LOWER_RESET 16'h8000
`define ACC_UPPER_RESET 16'h7fff

`define ACC_BIT_TRIGGER 15
`define ACC_BIT_MODE 8
`define ACC_BIT_STYLE 4
`define ACC_BIT_POL 3
`define ACC_BIT_LATCH 2
`define ACC_QUEUE_OFF 2'h3

`define ACC_READY_PULSE_NS 8000
`define ACC_CLK_NS 25
`define ACC_READY_PULSE_CYC ((`ACC_READY_PULSE_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)

`endif

// ===== logic/acc_pkg.sv
/*
  Types shared by the configuration and alert control block.
  Assumes acc_defs.svh is on the include path.
*/
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_RX_HI,
    ACC_RX_LO
  } acc_wstate_t;
endpackage : acc_pkg

// ===== logic/acc_alert.sv
/*
  Comparator, queue counter and alert pin driver.
  Assumes one conversion-done pulse per result and configuration fields
  from the register block on the same clock.
*/
`timescale 1ns/1ps
`include "acc_defs.svh"

module acc_alert (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Configuration
  input wire logic [15:0] cfg,
  input wire logic [15:0] upper_limit,
  input wire logic [15:0] lower_limit,
  input wire logic busy,
  // Conversion events
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  input wire logic latch_clear,
  // Pin
  output logic alert_out,
  output logic alert_oe,
  output logic alert_active
);

  logic [2:0] hits;
  logic [2:0] next_hits;
  logic asserted;
  logic next_asserted;
  logic [8:0] pulse_cnt;
  logic [8:0] next_pulse_cnt;
  logic [2:0] need;
  logic over;
  logic under;
  logic outside;
  logic ready_mode;
  logic level;

  // Queue depth: one, two or four successive results
  always_comb begin
    unique case (cfg[1:0])
      2'h0: need = 3'h1;
      2'h1: need = 3'h2;
      default: need = 3'h4;
    endcase
  end

  // Signed compare against the limits
  assign over = $signed(conv_data) > $signed(upper_limit);
  assign under = $signed(conv_data) <= $signed(lower_limit);
  assign ready_mode = upper_limit[15] && !lower_limit[15];

  // Traditional mode keeps hysteresis, window mode trips on either side
  assign outside = cfg[`ACC_BIT_STYLE] ? (over || under) : over;

  always_comb begin
    next_hits = hits;
    next_asserted = asserted;
    next_pulse_cnt = (pulse_cnt != 9'h0) ? pulse_cnt - 9'h1 : 9'h0;
    if (cfg[1:0] == `ACC_QUEUE_OFF) begin
      next_hits = 3'h0;
      next_asserted = 1'b0;
    end else if (conv_done) begin
      if (outside) begin
        next_hits = (hits < need) ? hits + 3'h1 : hits;
        if (hits + 3'h1 >= need)
          next_asserted = 1'b1;
      end else begin
        next_hits = 3'h0;
        // Release waits for the lower limit in traditional mode
        if (!cfg[`ACC_BIT_LATCH] && (cfg[`ACC_BIT_STYLE] || under))
          next_asserted = 1'b0;
      end
      if (!cfg[`ACC_BIT_MODE])
        next_pulse_cnt = 9'(`ACC_READY_PULSE_CYC);
    end else if (latch_clear && cfg[`ACC_BIT_LATCH]) begin
      next_asserted = 1'b0;
    end
  end

  // Register state
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hits <= 3'h0;
      asserted <= 1'b0;
      pulse_cnt <= 9'h0;
    end else begin
      hits <= next_hits;
      asserted <= next_asserted;
      pulse_cnt <= next_pulse_cnt;
    end
  end

  // Ready mode mirrors status in single-shot, pulses in continuous
  always_comb begin
    if (ready_mode)
      level = cfg[`ACC_BIT_MODE] ? !busy : (pulse_cnt != 9'h0);
    else
      level = asserted;
  end

  assign alert_active = level && (cfg[1:0] != `ACC_QUEUE_OFF);
  assign alert_out = cfg[`ACC_BIT_POL] ? alert_active : !alert_active;
  assign alert_oe = cfg[1:0] != `ACC_QUEUE_OFF;

endmodule : acc_alert

// ===== test/acc_ctrl_asserts.sv
/* Checker for acc_ctrl: launch, status, alert response, read data.
   Assumes it is bound to acc_ctrl and sees only its ports. */
`timescale 1ns/1ps
module acc_chk #(parameter logic [6:0] OWN_ADDR = 7'h48) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Host bytes
  input wire logic wr_byte_valid,
  input wire logic rd_byte_req,
  input wire logic [7:0] rd_byte,
  input wire logic alert_resp,
  input wire logic [7:0] alert_resp_byte,
  // Core and pin
  input wire logic conv_start,
  input wire logic conv_continuous,
  input wire logic conv_done,
  input wire logic alert_oe,
  input wire logic busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Single-shot completion
  sequence s_done;
    conv_done && !conv_continuous;
  endsequence
  // Launch right after the final written byte
  sequence s_launch;
    conv_start && $past(wr_byte_valid);
  endsequence
  chk_launch_cause: assert property (conv_start |-> $past(wr_byte_valid)) else $error("start no write");
  chk_launch_idle: assert property (conv_start |-> !$past(busy)) else $error("start busy");
  chk_launch_one: assert property (s_launch |=> !conv_start) else $error("start long");
  chk_status_busy: assert property (s_launch |-> busy) else $error("busy unset");
  // Mode changes skipped: busy may follow the new mode
  chk_busy_hold: assert property (busy && !conv_done && !conv_continuous && $stable(conv_continuous) |=> busy)
    else $error("busy drop");
  chk_done_clear: assert property (s_done |=> !busy) else $error("busy stuck");
  chk_resp_addr: assert property (alert_resp && alert_oe |=>
    alert_resp_byte == {OWN_ADDR, 1'b0} || $stable(alert_resp_byte)) else $error("resp addr");
  chk_resp_quiet: assert property (alert_resp && !alert_oe |=> $stable(alert_resp_byte)) else $error("resp off");
  chk_read_hold: assert property (!rd_byte_req |=> $stable(rd_byte)) else $error("rd moved");
endmodule : acc_chk
bind acc_ctrl acc_chk #(.OWN_ADDR(OWN_ADDR)) acc_chk_inst (.mclk, .nrst, .wr_byte_valid, .rd_byte_req,
  .rd_byte, .alert_resp, .alert_resp_byte, .conv_start, .conv_continuous, .conv_done, .alert_oe, .busy);

// ===== test/acc_hm.sv
/* Byte-level bus host model: frames, pointer and data bytes, reads.
   Assumes bytes are taken on mclk rising edges. */
`timescale 1ns/1ps
module acc_hm (
  // Clock
  input wire logic mclk,
  // Strobes to target
  output logic frame_start,
  output logic wr_byte_valid,
  output logic [7:0] wr_byte,
  output logic rd_byte_req,
  output logic alert_resp,
  // Read data
  input wire logic [7:0] rd_byte
);
  int gap = 0; // Idle cycles per byte, plays a slow host
  initial begin
    {frame_start, wr_byte_valid, rd_byte_req, alert_resp} = 4'h0;
    wr_byte = 8'h00;
  end
  // One-cycle strobe; idle lane shows the inverse, never a stale byte
  task automatic pulse(input int k, input logic [7:0] b);
    @(posedge mclk);
    #1;
    {frame_start, wr_byte_valid, rd_byte_req, alert_resp} = 4'h8 >> k;
    wr_byte = b;
    @(posedge mclk);
    #1;
    {frame_start, wr_byte_valid, rd_byte_req, alert_resp} = 4'h0;
    wr_byte = ~b;
    repeat (gap) @(posedge mclk);
  endtask : pulse
  // Pointer, then most significant byte first
  task automatic wr3(input logic [1:0] p, input logic [15:0] v);
    pulse(0, 8'h00);
    pulse(1, {6'h00, p});
    pulse(1, v[15:8]);
    pulse(1, v[7:0]);
  endtask : wr3
  // Point, then read two bytes in a fresh frame
  task automatic rd2(input logic [1:0] p, output logic [15:0] v);
    pulse(0, 8'h00);
    pulse(1, {6'h00, p});
    pulse(0, 8'h00);
    pulse(2, 8'h00);
    v[15:8] = rd_byte;
    pulse(2, 8'h00);
    v[7:0] = rd_byte;
  endtask : rd2
endmodule : acc_hm

// ===== test/tb.sv
/* Self-checking bench for acc_ctrl: config word, launch, status, alert pin.
   Assumes acc_hm drives the byte port and the bench plays the core. */
`timescale 1ns/1ps
`include "acc_defs.svh"
module tb;
  logic mclk, nrst, conv_done, frame_start, wr_byte_valid, rd_byte_req, alert_resp;
  logic conv_start, conv_continuous, alert_out, alert_oe, busy;
  logic [7:0] wr_byte, rd_byte, alert_resp_byte;
  logic [2:0] input_pair_select, gain_range_select, rate_select;
  logic [15:0] conv_data, lfsr, v, w;
  int mismatches = 0, n_checks = 0, n_start = 0, cyc = 0;
  acc_ctrl acc_ctrl_inst (.mclk, .nrst, .frame_start, .wr_byte_valid, .wr_byte, .rd_byte_req, .rd_byte,
    .alert_resp, .alert_resp_byte, .conv_start, .conv_continuous, .input_pair_select, .gain_range_select,
    .rate_select, .conv_done, .conv_data, .alert_out, .alert_oe, .busy);
  acc_hm acc_hm_inst (.mclk, .frame_start, .wr_byte_valid, .wr_byte, .rd_byte_req, .alert_resp, .rd_byte);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Launch count and hang guard
  always @(posedge mclk) begin
    if (conv_start === 1'b1) n_start++;
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  // Pin level for alert state and polarity
  function automatic logic pin(input logic a, input logic pol);
    return pol ? a : !a;
  endfunction : pin
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Core result; data lane inverted when idle
  task automatic conv(input logic [15:0] d);
    @(posedge mclk);
    #1;
    conv_done = 1'b1;
    conv_data = d;
    @(posedge mclk);
    #1;
    conv_done = 1'b0;
    conv_data = ~d;
  endtask : conv
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial begin
    nrst = 1'b0;
    conv_done = 1'b0;
    conv_data = 16'h0000;
    lfsr = 16'h15b4; // Seed 5556
    repeat (10) @(posedge mclk);
    #1 nrst = 1'b1;
    acc_hm_inst.rd2(2'h1, v);
    chk("cfg", 16'h8583, v);
    chk("oe", 16'h0000, alert_oe);
    chk("cont", 16'h0000, conv_continuous);
    chk("busy", 16'h0000, busy);
    chk("sel", 16'h0014, {input_pair_select, gain_range_select, rate_select});
    $display("reset done");
    // Every input, gain, rate and queue code, single-shot mode, random comparator bits, no launch
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      w = {1'b0, i[2:0], i[2:0], 1'b1, i[2:0], lfsr[4:2], i[1:0]};
      acc_hm_inst.wr3(2'h1, w);
      acc_hm_inst.rd2(2'h1, v);
      chk("cfg", w | 16'h8000, v);
      chk("sel", {i[2:0], i[2:0], i[2:0]}, {input_pair_select, gain_range_select, rate_select});
      chk("oe", i[1:0] != 2'h3, alert_oe);
    end
    acc_hm_inst.pulse(3, 8'h00);
    chk("resp", 8'hff, alert_resp_byte);
    $display("fields done");
    // Launch, refused relaunch while busy, slow host
    acc_hm_inst.gap = 2;
    acc_hm_inst.wr3(2'h1, 16'h8583);
    acc_hm_inst.wr3(2'h1, 16'h8583);
    chk("starts", 16'h0001, n_start[15:0]);
    chk("busy", 16'h0001, busy);
    acc_hm_inst.rd2(2'h1, v);
    chk("stat", 16'h0583, v);
    lfsr = nxt(lfsr);
    conv(lfsr);
    acc_hm_inst.rd2(2'h1, v);
    chk("stat", 16'h8583, v);
    acc_hm_inst.rd2(2'h0, v);
    chk("result", {lfsr[15:4], 4'h0}, v);
    acc_hm_inst.gap = 0;
    acc_hm_inst.wr3(2'h1, 16'h8483);
    chk("cont", 16'h0001, conv_continuous);
    chk("starts", 16'h0001, n_start[15:0]);
    $display("launch done");
    // Limits upper 1000, lower 0000; depths 1, 2, 4
    acc_hm_inst.wr3(2'h3, 16'h1000);
    acc_hm_inst.wr3(2'h2, 16'h0000);
    for (int q = 0; q < 3; q++) begin
      lfsr = nxt(lfsr);
      acc_hm_inst.wr3(2'h1, 16'h0580 | q[1:0]);
      conv(16'h0000);
      repeat ((1 << q) - 1) conv({4'h2, lfsr[11:0]});
      chk("pre", pin(0, 0), alert_out);
      conv({4'h2, lfsr[11:0]});
      chk("trip", pin(1, 0), alert_out);
      conv(16'h0000);
      chk("rel", pin(0, 0), alert_out);
    end
    $display("queue done");
    // Active-high latched pin
    acc_hm_inst.wr3(2'h1, 16'h058c);
    conv(16'h2000);
    conv(16'h0000);
    chk("latch", pin(1, 1), alert_out);
    acc_hm_inst.rd2(2'h0, v);
    chk("clear", pin(0, 1), alert_out);
    conv(16'h2000);
    acc_hm_inst.pulse(3, 8'h00);
    chk("resp", 8'h90, alert_resp_byte);
    $display("latch done");
    // Window trips below lower limit
    acc_hm_inst.wr3(2'h1, 16'h0590);
    conv(16'h0800);
    chk("win in", pin(0, 0), alert_out);
    conv(16'h8000);
    chk("win lo", pin(1, 0), alert_out);
    $display("window done");
    // Ready mode: upper MSB set, lower MSB clear; pin follows status, then pulses
    acc_hm_inst.wr3(2'h3, 16'h8000);
    chk("rdy idle", pin(1, 0), alert_out);
    acc_hm_inst.wr3(2'h1, 16'h8590);
    chk("busy", 16'h0001, busy);
    chk("rdy busy", pin(0, 0), alert_out);
    lfsr = nxt(lfsr);
    conv(lfsr);
    chk("busy", 16'h0000, busy);
    chk("rdy done", pin(1, 0), alert_out);
    // Continuous: pulse lasts the ready count, measured from the done edge
    acc_hm_inst.wr3(2'h1, 16'h0490);
    chk("rdy cont", pin(0, 0), alert_out);
    conv(lfsr);
    repeat (`ACC_READY_PULSE_CYC - 1) @(posedge mclk);
    #1;
    chk("rdy pulse", pin(1, 0), alert_out);
    @(posedge mclk);
    #1;
    chk("rdy end", pin(0, 0), alert_out);
    chk("busy", 16'h0001, busy);
    $display("ready done");
    test_done();
  end
endmodule : tb
